// ===== src/nhb_pkg.sv
// Constants, types and helpers of the network management / heartbeat node.
// Assumes one 100 MHz clock and a CAN controller that hands over whole frames.
//
// Functional notes
// - Nonzero producer interval sends periodic heartbeat, ms
// - Heartbeat identifier is 700h plus node address
// - Heartbeat byte zero carries current state code
// - Zero producer interval: no heartbeat at all
// - Consumer entry: zero, node address, timeout
// - Supervision starts on heartbeat with configured entry
// - Consumer timeout expiry deactivates that supervision
// - Zero consumer timeout disables consumer entirely
// - Guard request answered with state and toggle bit
// - Life guarding starts at first guard request
// - Life time is guard time times factor
// - Default identifiers are base plus node address
// - Base identifiers per function as listed
// - Power-on enters init, then pre-operational automatically
// - Process data only after start reaches operational
// - Stop, pre-op and reset commands from running states
// - Reset node resets all, reset comm parameters
// - Dictionary by service data; process data operational only
// - Digital and analog inputs map to dictionary entries
// - Two analog outputs map to 6410h words
// - State command: identifier zero, command, node address
// - Stopped suspends data traffic, keeps guarding and heartbeat
package nhb_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int NUM_CONS = 2;

	localparam logic [10:0] COB_NMT = 11'h000;
	localparam logic [10:0] COB_EMCY = 11'h080;
	localparam logic [10:0] COB_TPDO1 = 11'h180;
	localparam logic [10:0] COB_RPDO1 = 11'h200;
	localparam logic [10:0] COB_TPDO2 = 11'h280;
	localparam logic [10:0] COB_RPDO2 = 11'h300;
	localparam logic [10:0] COB_TPDO3 = 11'h380;
	localparam logic [10:0] COB_RPDO3 = 11'h400;
	localparam logic [10:0] COB_TSDO = 11'h580;
	localparam logic [10:0] COB_RSDO = 11'h600;
	localparam logic [10:0] COB_GUARD = 11'h700;

	localparam logic [7:0] HB_BOOT = 8'h00;
	localparam logic [7:0] HB_STOP = 8'h04;
	localparam logic [7:0] HB_OPER = 8'h05;
	localparam logic [7:0] HB_PREOP = 8'h7F;

	localparam logic [7:0] CMD_START = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] CMD_PREOP = 8'h80;
	localparam logic [7:0] CMD_RST_NODE = 8'h81;
	localparam logic [7:0] CMD_RST_COMM = 8'h82;

	localparam logic [15:0] OD_GUARD_TIME = 16'h100C;
	localparam logic [15:0] OD_LIFE_FACTOR = 16'h100D;
	localparam logic [15:0] OD_NODE_ADDR = 16'h100B;
	localparam logic [15:0] OD_CONS_HB = 16'h1016;
	localparam logic [15:0] OD_PROD_HB = 16'h1017;
	localparam logic [15:0] OD_DIG_IN = 16'h6000;
	localparam logic [15:0] OD_DIG_OUT = 16'h6200;
	localparam logic [15:0] OD_ANA_IN = 16'h6401;
	localparam logic [15:0] OD_ANA_OUT = 16'h6410;

	localparam int CONS_ZERO_LSB = 24;
	localparam int CONS_NODE_LSB = 16;
	localparam int CONS_TIME_LSB = 0;

	localparam logic [15:0] PROD_HB_RST = 16'h0000;
	localparam logic [15:0] GUARD_TIME_RST = 16'h0000;
	localparam logic [7:0] LIFE_FACTOR_RST = 8'h00;
	localparam logic [31:0] CONS_HB_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_PREOP = 2'b01,
		ST_OPER = 2'b10,
		ST_STOP = 2'b11
	} nhb_state_t;

	typedef enum logic [1:0] {
		TX_NONE = 2'b00,
		TX_BOOT = 2'b01,
		TX_HB = 2'b10,
		TX_GUARD = 2'b11
	} nhb_tx_kind_t;

	typedef struct packed {
		logic valid;
		logic [10:0] id;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} nhb_frame_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} nhb_od_req_t;

	typedef struct packed {
		logic [10:0] emcy;
		logic [10:0] tpdo1;
		logic [10:0] rpdo1;
		logic [10:0] tpdo2;
		logic [10:0] rpdo2;
		logic [10:0] tpdo3;
		logic [10:0] rpdo3;
		logic [10:0] tsdo;
		logic [10:0] rsdo;
		logic [10:0] guard;
	} nhb_cob_ids_t;

	function automatic logic [10:0] cob_id(input logic [10:0] base, input logic [7:0] addr);
		return base + {3'b000, addr};
	endfunction

	function automatic logic [7:0] state_code(input nhb_state_t st);
		case (st)
			ST_INIT: return HB_BOOT;
			ST_PREOP: return HB_PREOP;
			ST_OPER: return HB_OPER;
			ST_STOP: return HB_STOP;
			default: return HB_BOOT;
		endcase
	endfunction

	function automatic logic od_is(input nhb_od_req_t r, input logic [15:0] idx,
		input logic [7:0] sub);
		return (r.index == idx) && (r.sub == sub);
	endfunction

endpackage

// ===== src/nhb_ms_tick.sv
// Millisecond tick divider for the node's timers.
// Assumes a free-running clock; the tick is a one-cycle pulse.
`timescale 1ns/1ps
module nhb_ms_tick #(
	parameter int TICK_CYCLES = nhb_pkg::MS_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	output logic tick
);
	import nhb_pkg::*;

	logic [31:0] cnt_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
			cnt_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick <= 1'b0;
		end
	end

endmodule // nhb_ms_tick

// ===== src/nhb_hb_consumer.sv
// One heartbeat consumer slot: supervision flag and timeout counter.
// Assumes hb_hit already matches the entry's node address.
`timescale 1ns/1ps
module nhb_hb_consumer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ms_tick,
	input wire logic [31:0] entry,
	input wire logic hb_hit,
	output logic active,
	output logic timeout
);
	import nhb_pkg::*;

	logic [15:0] cnt_q;
	logic [15:0] limit;

	assign limit = entry[CONS_TIME_LSB +: 16];

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	always_ff @(posedge clock) begin
		if (sys_rst || limit == 16'h0000) begin
			active <= 1'b0;
			cnt_q <= 16'h0000;
			timeout <= 1'b0;
		end else if (hb_hit) begin
			active <= 1'b1;
			cnt_q <= 16'h0000;
			timeout <= 1'b0;
		end else if (active && ms_tick && cnt_q == limit - 16'h0001) begin
			active <= 1'b0;
			cnt_q <= 16'h0000;
			timeout <= 1'b1;
		end else begin
			if (active && ms_tick)
				cnt_q <= cnt_q + 16'h0001;
			timeout <= 1'b0;
		end
	end

	cons_expire_a: assert property (timeout |-> !active && $past(active))
		else $error("timeout without a live supervision");
	cons_zero_a: assert property (limit == 16'h0000 |=> !active && !timeout)
		else $error("consumer alive with zero timeout");
	cons_start_a: assert property (hb_hit && limit != 16'h0000
		|=> active && cnt_q == 16'h0000)
		else $error("heartbeat did not start supervision");

endmodule // nhb_hb_consumer

// ===== src/nhb_node.sv
// Network management and heartbeat logic of a fieldbus I/O node.
// Assumes whole received frames arrive as one-cycle strobes and the
// dictionary port is driven by the service data server.
`timescale 1ns/1ps
module nhb_node #(
	parameter int TICK_CYCLES = nhb_pkg::MS_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] target_node_address,
	input wire nhb_pkg::nhb_frame_t rx_frame,
	input wire logic tx_ready,
	output nhb_pkg::nhb_frame_t tx_frame,
	input wire nhb_pkg::nhb_od_req_t od_req,
	output logic od_ack,
	output logic od_err,
	output logic [31:0] od_rdata,
	input wire logic [26:0] digital_input_bit,
	input wire logic [3:0][15:0] analog_input_channel,
	output logic [15:0] digital_output_bit,
	output logic [3:0] relay_output_bit,
	output logic [1:0][15:0] analog_output_channel,
	output nhb_pkg::nhb_state_t node_state,
	output logic pdo_enable,
	output logic sdo_enable,
	output logic emcy_enable,
	output logic app_reset,
	output nhb_pkg::nhb_cob_ids_t cob_ids,
	output logic [nhb_pkg::NUM_CONS-1:0] consumer_active,
	output logic [nhb_pkg::NUM_CONS-1:0] consumer_timeout,
	output logic life_guard_fail
);
	import nhb_pkg::*;

	nhb_state_t state_q;
	nhb_tx_kind_t tx_kind_q;
	logic [15:0] prod_ms_q;
	logic [15:0] prod_cnt_q;
	logic [15:0] guard_ms_q;
	logic [7:0] life_fac_q;
	logic [NUM_CONS-1:0][31:0] cons_entry_q;
	logic boot_pend_q;
	logic hb_pend_q;
	logic guard_pend_q;
	logic toggle_q;
	logic guard_on_q;
	logic [23:0] life_cnt_q;
	logic comm_rst_q;
	logic ms_tick;
	logic comm_rst;
	logic nmt_hit;
	logic cmd_ok;
	logic [7:0] nmt_cmd;
	logic guard_req;
	logic [NUM_CONS-1:0] hb_hit;
	logic hb_fire;
	logic tx_free;
	logic ld_boot;
	logic ld_guard;
	logic ld_hb;
	logic od_open;
	logic od_known;
	logic od_ro;
	logic od_bad_val;
	logic [31:0] od_rd;
	logic [23:0] life_time;
	logic [7:0] st_code;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	nhb_ms_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.sys_rst(sys_rst),
		.tick(ms_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Frame decode

	assign comm_rst = sys_rst || comm_rst_q;
	assign nmt_cmd = rx_frame.data[7:0];
	assign nmt_hit = rx_frame.valid && !rx_frame.rtr && rx_frame.id == COB_NMT
		&& rx_frame.dlc >= 4'h2
		&& (rx_frame.data[15:8] == target_node_address || rx_frame.data[15:8] == 8'h00);
	// Commands are ignored while initialization is still running
	assign cmd_ok = nmt_hit && state_q != ST_INIT;
	assign guard_req = rx_frame.valid && rx_frame.rtr
		&& rx_frame.id == cob_id(COB_GUARD, target_node_address);

	generate
		for (genvar i = 0; i < NUM_CONS; i++) begin : g_cons
			assign hb_hit[i] = rx_frame.valid && !rx_frame.rtr && rx_frame.dlc != 4'h0
				&& cons_entry_q[i][CONS_NODE_LSB +: 8] != 8'h00
				&& rx_frame.id == cob_id(COB_GUARD, cons_entry_q[i][CONS_NODE_LSB +: 8]);
			nhb_hb_consumer u_cons (
				.clock(clock),
				.sys_rst(comm_rst),
				.ms_tick(ms_tick),
				.entry(cons_entry_q[i]),
				.hb_hit(hb_hit[i]),
				.active(consumer_active[i]),
				.timeout(consumer_timeout[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Node state machine

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= ST_INIT;
		end else begin
			case (state_q)
				ST_INIT: state_q <= ST_PREOP;
				ST_PREOP, ST_OPER, ST_STOP: begin
					if (cmd_ok) begin
						case (nmt_cmd)
							CMD_START: state_q <= ST_OPER;
							CMD_STOP: state_q <= ST_STOP;
							CMD_PREOP: state_q <= ST_PREOP;
							CMD_RST_NODE, CMD_RST_COMM: state_q <= ST_INIT;
							default: state_q <= state_q;
						endcase
					end
				end
				default: state_q <= ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			comm_rst_q <= 1'b0;
			app_reset <= 1'b0;
		end else begin
			app_reset <= cmd_ok && nmt_cmd == CMD_RST_NODE;
			comm_rst_q <= cmd_ok && (nmt_cmd == CMD_RST_NODE || nmt_cmd == CMD_RST_COMM);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			node_state <= ST_INIT;
			pdo_enable <= 1'b0;
			sdo_enable <= 1'b0;
			emcy_enable <= 1'b0;
			cob_ids <= '0;
		end else begin
			node_state <= state_q;
			pdo_enable <= state_q == ST_OPER;
			sdo_enable <= state_q == ST_PREOP || state_q == ST_OPER;
			emcy_enable <= state_q == ST_PREOP || state_q == ST_OPER;
			cob_ids.emcy <= cob_id(COB_EMCY, target_node_address);
			cob_ids.tpdo1 <= cob_id(COB_TPDO1, target_node_address);
			cob_ids.rpdo1 <= cob_id(COB_RPDO1, target_node_address);
			cob_ids.tpdo2 <= cob_id(COB_TPDO2, target_node_address);
			cob_ids.rpdo2 <= cob_id(COB_RPDO2, target_node_address);
			cob_ids.tpdo3 <= cob_id(COB_TPDO3, target_node_address);
			cob_ids.rpdo3 <= cob_id(COB_RPDO3, target_node_address);
			cob_ids.tsdo <= cob_id(COB_TSDO, target_node_address);
			cob_ids.rsdo <= cob_id(COB_RSDO, target_node_address);
			cob_ids.guard <= cob_id(COB_GUARD, target_node_address);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Dictionary port

	// Service data is refused before boot-up completes and while stopped
	assign od_open = state_q == ST_PREOP || state_q == ST_OPER;

	always_comb begin
		od_rd = 32'h0;
		od_known = 1'b1;
		od_ro = 1'b0;
		od_bad_val = 1'b0;
		if (od_is(od_req, OD_PROD_HB, 8'h00)) begin
			od_rd = {16'h0, prod_ms_q};
		end else if (od_is(od_req, OD_GUARD_TIME, 8'h00)) begin
			od_rd = {16'h0, guard_ms_q};
		end else if (od_is(od_req, OD_LIFE_FACTOR, 8'h00)) begin
			od_rd = {24'h0, life_fac_q};
		end else if (od_is(od_req, OD_NODE_ADDR, 8'h00)) begin
			od_rd = {24'h0, target_node_address};
			od_ro = 1'b1;
		end else if (od_is(od_req, OD_CONS_HB, 8'h00)) begin
			od_rd = 32'(NUM_CONS);
			od_ro = 1'b1;
		end else if (od_req.index == OD_CONS_HB && od_req.sub != 8'h00
			&& od_req.sub <= 8'(NUM_CONS)) begin
			od_rd = cons_entry_q[od_req.sub[0:0] - 1'b1];
			od_bad_val = od_req.wdata[CONS_ZERO_LSB +: 8] != 8'h00;
		end else if (od_req.index == OD_DIG_IN && od_req.sub >= 8'h01 && od_req.sub <= 8'h04) begin
			od_rd = {24'h0, 8'({5'h0, digital_input_bit} >> {od_req.sub - 8'h01, 3'b000})};
			od_ro = 1'b1;
		end else if (od_is(od_req, OD_DIG_OUT, 8'h01)) begin
			od_rd = {24'h0, digital_output_bit[7:0]};
		end else if (od_is(od_req, OD_DIG_OUT, 8'h02)) begin
			od_rd = {24'h0, digital_output_bit[15:8]};
		end else if (od_is(od_req, OD_DIG_OUT, 8'h03)) begin
			od_rd = {28'h0, relay_output_bit};
		end else if (od_req.index == OD_ANA_IN && od_req.sub >= 8'h01 && od_req.sub <= 8'h04) begin
			od_rd = {16'h0, analog_input_channel[od_req.sub[1:0] - 2'b01]};
			od_ro = 1'b1;
		end else if (od_req.index == OD_ANA_OUT && (od_req.sub == 8'h01 || od_req.sub == 8'h02)) begin
			od_rd = {16'h0, analog_output_channel[od_req.sub[1]]};
		end else begin
			od_known = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			od_ack <= 1'b0;
			od_err <= 1'b0;
			od_rdata <= 32'h0;
		end else begin
			od_ack <= od_req.valid;
			od_err <= od_req.valid && (!od_open || !od_known
				|| (od_req.write && (od_ro || od_bad_val)));
			od_rdata <= (od_req.valid && !od_req.write && od_open) ? od_rd : 32'h0;
		end
	end

	function automatic logic od_wr(input logic [15:0] idx, input logic [7:0] sub);
		return od_req.valid && od_req.write && od_open && od_is(od_req, idx, sub);
	endfunction

	// Communication parameters fall back to defaults on either reset command
	always_ff @(posedge clock) begin
		if (comm_rst) begin
			prod_ms_q <= PROD_HB_RST;
			guard_ms_q <= GUARD_TIME_RST;
			life_fac_q <= LIFE_FACTOR_RST;
			cons_entry_q <= {NUM_CONS{CONS_HB_RST}};
		end else begin
			if (od_wr(OD_PROD_HB, 8'h00))
				prod_ms_q <= od_req.wdata[15:0];
			if (od_wr(OD_GUARD_TIME, 8'h00))
				guard_ms_q <= od_req.wdata[15:0];
			if (od_wr(OD_LIFE_FACTOR, 8'h00))
				life_fac_q <= od_req.wdata[7:0];
			for (int i = 0; i < NUM_CONS; i++) begin
				if (od_wr(OD_CONS_HB, 8'(i + 1)) && !od_bad_val)
					cons_entry_q[i] <= od_req.wdata;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || app_reset) begin
			digital_output_bit <= 16'h0000;
			relay_output_bit <= 4'h0;
			analog_output_channel <= '0;
		end else begin
			if (od_wr(OD_DIG_OUT, 8'h01))
				digital_output_bit[7:0] <= od_req.wdata[7:0];
			if (od_wr(OD_DIG_OUT, 8'h02))
				digital_output_bit[15:8] <= od_req.wdata[7:0];
			if (od_wr(OD_DIG_OUT, 8'h03))
				relay_output_bit <= od_req.wdata[3:0];
			if (od_wr(OD_ANA_OUT, 8'h01))
				analog_output_channel[0] <= od_req.wdata[15:0];
			if (od_wr(OD_ANA_OUT, 8'h02))
				analog_output_channel[1] <= od_req.wdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Heartbeat producer and life guarding

	assign hb_fire = ms_tick && prod_ms_q != 16'h0000 && state_q != ST_INIT
		&& prod_cnt_q == prod_ms_q - 16'h0001;
	assign life_time = {8'h00, guard_ms_q} * {16'h0000, life_fac_q};

	always_ff @(posedge clock) begin
		if (comm_rst || prod_ms_q == 16'h0000)
			prod_cnt_q <= 16'h0000;
		else if (hb_fire)
			prod_cnt_q <= 16'h0000;
		else if (ms_tick)
			prod_cnt_q <= prod_cnt_q + 16'h0001;
	end

	always_ff @(posedge clock) begin
		if (comm_rst) begin
			guard_on_q <= 1'b0;
			life_cnt_q <= 24'h0;
			life_guard_fail <= 1'b0;
		end else if (guard_req) begin
			guard_on_q <= 1'b1;
			life_cnt_q <= 24'h0;
			life_guard_fail <= 1'b0;
		end else if (guard_on_q && ms_tick && life_time != 24'h0
			&& life_cnt_q == life_time - 24'h1) begin
			guard_on_q <= 1'b0;
			life_cnt_q <= 24'h0;
			life_guard_fail <= 1'b1;
		end else begin
			if (guard_on_q && ms_tick && life_time != 24'h0)
				life_cnt_q <= life_cnt_q + 24'h1;
			life_guard_fail <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit arbitration: boot-up, then guard answer, then heartbeat

	assign tx_free = !tx_frame.valid || tx_ready;
	assign ld_boot = tx_free && boot_pend_q;
	assign ld_guard = tx_free && !boot_pend_q && guard_pend_q;
	assign ld_hb = tx_free && !boot_pend_q && !guard_pend_q && hb_pend_q;
	assign st_code = state_code(state_q);

	// A new event wins over the clear of the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			boot_pend_q <= 1'b0;
			guard_pend_q <= 1'b0;
			hb_pend_q <= 1'b0;
		end else begin
			boot_pend_q <= (state_q == ST_INIT) || (boot_pend_q && !ld_boot);
			guard_pend_q <= guard_req || (guard_pend_q && !ld_guard);
			hb_pend_q <= (hb_fire || (hb_pend_q && !ld_hb)) && prod_ms_q != 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (comm_rst)
			toggle_q <= 1'b0;
		else if (ld_guard)
			toggle_q <= !toggle_q;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_frame <= '0;
			tx_kind_q <= TX_NONE;
		end else if (tx_free) begin
			tx_frame.valid <= ld_boot || ld_guard || ld_hb;
			tx_frame.id <= cob_id(COB_GUARD, target_node_address);
			tx_frame.rtr <= 1'b0;
			tx_frame.dlc <= 4'h1;
			if (ld_boot) begin
				tx_frame.data <= {56'h0, HB_BOOT};
				tx_kind_q <= TX_BOOT;
			end else if (ld_guard) begin
				tx_frame.data <= {56'h0, toggle_q, st_code[6:0]};
				tx_kind_q <= TX_GUARD;
			end else if (ld_hb) begin
				tx_frame.data <= {56'h0, st_code};
				tx_kind_q <= TX_HB;
			end else begin
				tx_frame.data <= 64'h0;
				tx_kind_q <= TX_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	boot_to_preop_a: assert property (state_q == ST_INIT |=> state_q == ST_PREOP)
		else $error("init did not fall through to pre-operational");
	start_oper_a: assert property (cmd_ok && nmt_cmd == CMD_START
		&& (state_q == ST_PREOP || state_q == ST_STOP) |=> state_q == ST_OPER)
		else $error("start command did not reach operational");
	pdo_gate_a: assert property ((state_q == ST_OPER) |=> pdo_enable == 1'b1 ##0
		($past(state_q) == ST_OPER))
		else $error("process data gate wrong");
	hb_quiet_a: assert property (prod_ms_q == 16'h0000 |=> !hb_pend_q && !ld_hb)
		else $error("heartbeat pending with zero interval");
	hb_ident_a: assert property (tx_frame.valid |-> tx_frame.id
		== cob_id(COB_GUARD, target_node_address))
		else $error("heartbeat identifier wrong");
	hb_state_a: assert property (ld_hb |=> tx_frame.valid && tx_kind_q == TX_HB
		&& tx_frame.data[7:0] == state_code($past(state_q)))
		else $error("heartbeat state byte wrong");
	guard_toggle_a: assert property (ld_guard && !comm_rst_q
		|=> toggle_q != $past(toggle_q))
		else $error("guard toggle did not alternate");
	life_start_a: assert property (life_guard_fail |-> $past(guard_on_q))
		else $error("life guard failure before first request");
	stop_sdo_a: assert property (od_req.valid && state_q == ST_STOP
		|=> od_ack && od_err)
		else $error("service data served while stopped");

endmodule // nhb_node

// ===== tb/nhb_can_peer.sv
// CAN controller model that takes the node's outgoing frames.
// Assumes tx_frame holds until tx_ready; slow stalls every other cycle.
`timescale 1ns/1ps
module nhb_can_peer (
	input wire logic clock,
	input wire logic slow,
	input wire nhb_pkg::nhb_frame_t tx_frame,
	output logic tx_ready,
	output nhb_pkg::nhb_frame_t got,
	output logic [7:0] n_got
);
	import nhb_pkg::*;
	logic ph_q = 1'b0;
	initial got = '0;
	initial n_got = 8'h00;
	// Stalling exposes a transmitter that drops a frame before acceptance
	assign tx_ready = tx_frame.valid && (!slow || ph_q);
	always @(posedge clock) ph_q <= !ph_q;
	always @(posedge clock) begin
		if (tx_ready) begin
			got <= tx_frame;
			n_got <= n_got + 8'h01;
		end
	end
endmodule // nhb_can_peer

// ===== tb/nhb_node_tb.sv
// Self-checking bench: boot, heartbeat, state commands, guarding, consumer.
// Assumes TICK_CYCLES of 10, so one ms is ten clock cycles.
`timescale 1ns/1ps
module network_mgmt_heartbeat_node_tb_top;
	import nhb_pkg::*;
	// Command table, entry 0 in the low bits
	localparam logic [55:0] CM = 56'h81_82_80_01_02_01_01;
	localparam logic [55:0] AD = 56'h05_05_05_05_00_05_06;
	localparam logic [13:0] XS = 14'h15B9;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic slow = 1'b0;
	logic tx_ready, od_ack, od_err, app_reset, lgf, pdo_en, sdo_en, emcy_en;
	logic [15:0] dout;
	logic [3:0] rel;
	logic [1:0][15:0] aout;
	logic [31:0] od_rdata;
	logic [1:0] c_act, c_to;
	logic [7:0] n_got;
	logic [7:0] base = 8'h00;
	nhb_frame_t rx_frame = '0;
	nhb_frame_t tx_frame, got;
	nhb_od_req_t od_req = '0;
	nhb_state_t node_state;
	nhb_cob_ids_t cob_ids;
	int error_cnt = 0;
	int compares = 0;
	int n_lgf = 0;
	int n_to = 0;
	int n_ar = 0;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (lgf === 1'b1) n_lgf++;
		if (c_to[0] === 1'b1) n_to++;
		if (app_reset === 1'b1) n_ar++;
	end
	nhb_node #(.TICK_CYCLES(10)) u_dut (
		.clock(clock), .sys_rst(sys_rst), .target_node_address(8'h05),
		.rx_frame(rx_frame), .tx_ready(tx_ready), .tx_frame(tx_frame), .od_req(od_req),
		.od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
		.digital_input_bit(27'h5A000C3), .analog_input_channel(64'h4444_3333_2222_1111),
		.digital_output_bit(dout), .relay_output_bit(rel), .analog_output_channel(aout),
		.node_state(node_state), .pdo_enable(pdo_en), .sdo_enable(sdo_en),
		.emcy_enable(emcy_en), .app_reset(app_reset), .cob_ids(cob_ids),
		.consumer_active(c_act), .consumer_timeout(c_to), .life_guard_fail(lgf));
	nhb_can_peer u_peer (.clock(clock), .slow(slow), .tx_frame(tx_frame),
		.tx_ready(tx_ready), .got(got), .n_got(n_got));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] wd, input logic er, input logic [31:0] rd);
		base = n_got;
		od_req = '{1'b1, w, ix, sb, wd};
		cyc(1);
		od_req = '0;
		chk({od_ack, od_err, od_rdata}, {1'b1, er, rd});
		cyc(1);
	endtask
	task automatic rx(input logic [10:0] id, input logic rtr, input logic [7:0] cm, ad);
		base = n_got;
		rx_frame = '{1'b1, id, rtr, 4'h2, {48'h0, ad, cm}};
		cyc(1);
		rx_frame = '0;
		cyc(1);
	endtask
	task automatic wf(input logic [7:0] b0);
		for (int i = 0; i < 40 && n_got == base; i++) cyc(1);
		if (n_got == base) begin
			error_cnt++;
			conclude();
		end else begin
			chk({got.id, got.dlc, got.data[7:0]}, {11'h705, 4'h1, b0});
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_boot();
		wf(8'h00);
		chk(node_state, ST_PREOP);
		chk(cob_ids, {11'h085, 11'h185, 11'h205, 11'h285, 11'h305, 11'h385, 11'h405,
			11'h585, 11'h605, 11'h705});
		od(1'b0, OD_DIG_IN, 8'h04, 0, 1'b0, 32'h05);
		od(1'b0, OD_ANA_IN, 8'h02, 0, 1'b0, 32'h2222);
		od(1'b1, OD_ANA_OUT, 8'h02, 32'h1234, 1'b0, 0);
		od(1'b0, OD_ANA_OUT, 8'h02, 0, 1'b0, 32'h1234);
		chk(aout[1], 16'h1234);
		od(1'b1, OD_DIG_OUT, 8'h02, 32'hA5, 1'b0, 0);
		od(1'b1, OD_DIG_OUT, 8'h03, 32'h0A, 1'b0, 0);
		chk({dout, rel}, {16'hA500, 4'hA});
	endtask
	task automatic s_hb();
		logic [7:0] n0;
		slow = 1'b1;
		od(1'b1, OD_PROD_HB, 8'h00, 32'h2, 1'b0, 0);
		wf(8'h7F);
		n0 = n_got;
		cyc(200);
		chk((n_got - n0) inside {[8'h09:8'h0B]}, 1'b1);
		od(1'b1, OD_PROD_HB, 8'h00, 0, 1'b0, 0);
		cyc(30);
		n0 = n_got;
		cyc(100);
		chk(n_got, n0);
		slow = 1'b0;
	endtask
	task automatic s_nmt();
		logic [1:0] x;
		od(1'b1, OD_GUARD_TIME, 8'h00, 32'h3, 1'b0, 0);
		for (int k = 0; k < 7; k++) begin
			x = XS[2*k +: 2];
			rx(11'h000, 1'b0, CM[8*k +: 8], AD[8*k +: 8]);
			cyc(3);
			chk(node_state, x);
			chk({pdo_en, sdo_en, emcy_en},
				{x == ST_OPER, {2{x inside {ST_OPER, ST_PREOP}}}});
			if (x == ST_STOP) begin
				od(1'b0, OD_PROD_HB, 8'h00, 0, 1'b1, 0);
				rx(11'h705, 1'b1, 8'h00, 8'h00);
				wf(8'h04);
			end
			if (k == 5) chk({dout, rel}, {16'hA500, 4'hA});
		end
		chk(n_ar, 1);
		chk({dout, rel, aout}, 52'h0);
		od(1'b0, OD_GUARD_TIME, 8'h00, 0, 1'b0, 0);
	endtask
	task automatic s_guard();
		int n0;
		od(1'b1, OD_GUARD_TIME, 8'h00, 32'h2, 1'b0, 0);
		od(1'b1, OD_LIFE_FACTOR, 8'h00, 32'h2, 1'b0, 0);
		cyc(100);
		chk(n_lgf, 0);
		rx(11'h705, 1'b1, 8'h00, 8'h00);
		wf(8'h7F);
		rx(11'h705, 1'b1, 8'h00, 8'h00);
		wf(8'hFF);
		n0 = n_lgf;
		cyc(25);
		chk(n_lgf, n0);
		cyc(30);
		chk(n_lgf, n0 + 1);
	endtask
	task automatic s_cons();
		int n0;
		od(1'b1, OD_CONS_HB, 8'h01, 32'h0109_0003, 1'b1, 0);
		od(1'b1, OD_CONS_HB, 8'h01, 32'h0009_0000, 1'b0, 0);
		rx(11'h709, 1'b0, 8'h05, 8'h00);
		chk(c_act, 2'b00);
		od(1'b1, OD_CONS_HB, 8'h01, 32'h0009_0003, 1'b0, 0);
		od(1'b0, OD_CONS_HB, 8'h01, 0, 1'b0, 32'h0009_0003);
		cyc(50);
		chk(c_act, 2'b00);
		repeat (4) begin
			rx(11'h709, 1'b0, 8'h05, 8'h00);
			chk(c_act, 2'b01);
			cyc(10);
		end
		n0 = n_to;
		cyc(50);
		chk({c_act, n_to - n0}, {2'b00, 1});
	endtask
	initial begin
		cyc(5);
		sys_rst = 1'b0;
		s_boot();
		s_hb();
		s_nmt();
		s_guard();
		s_cons();
		conclude();
	end
endmodule // network_mgmt_heartbeat_node_tb_top
